// ==== ces_pkg.sv ====
package ces_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_PERIOD_NS   = 10;        // 100 MHz system clock
    localparam int TICK_NS         = 1000000;   // Timer tick of 1 ms
    localparam int TICK_CYCLES     = TICK_NS / CLK_PERIOD_NS;
    localparam int DISCHARGE_MS    = 20;        // VBUS discharge time
    localparam int RESET_HOLD_MS   = 100;       // Switch held open, discharge included
    localparam int DISCHARGE_TICKS = DISCHARGE_MS * 1000000 / TICK_NS;
    localparam int HOLD_TICKS      = (RESET_HOLD_MS - DISCHARGE_MS) * 1000000 / TICK_NS;

    // ==========================================================
    // Profiles, in cycle order
    // ==========================================================
    localparam int       NUM_PROFILES = 9;
    localparam logic [3:0] PROF_LEG1   = 4'h0;
    localparam logic [3:0] PROF_DCP    = 4'h1;
    localparam logic [3:0] PROF_LEG2   = 4'h2;
    localparam logic [3:0] PROF_CUSTOM = 4'h8;
    localparam logic [3:0] PROF_CDP    = 4'h9;  // Only used outside the cycle
    localparam logic [3:0] STEP_LAST   = 4'h8;

    // ==========================================================
    // Current limit codes, 250 mA per step
    // ==========================================================
    localparam logic [3:0] LIMIT_1P5A  = 4'h6;

    // ==========================================================
    // Register word indices (byte address is four times index)
    // ==========================================================
    localparam logic [9:0] IDX_STATUS    = 10'h012;
    localparam logic [9:0] IDX_CTRL      = 10'h016;
    localparam logic [9:0] IDX_LIMIT     = 10'h019;
    localparam logic [9:0] IDX_TMO_BASE  = 10'h030;
    localparam logic [9:0] IDX_CUST_LIM  = 10'h051;

    // Control register fields
    localparam int CTRL_EN_LSB    = 0;   // Nine profile enables
    localparam int CTRL_FIRST_BIT = 9;   // custom_first_enable
    localparam int CTRL_RETRY_BIT = 10;  // cycle_retry_enable
    localparam int CTRL_TMO_BIT   = 11;  // Emulation timeout enable
    localparam int CTRL_HS_BIT    = 12;  // High-speed switch closed on no handshake
    localparam int FLOOR_LSB      = 2;   // accepted_floor_code bits 4..2

    // Reset values
    localparam logic [12:0] CTRL_RESET  = 13'h0CFF;
    localparam logic [3:0]  LIMIT_RESET = 4'h8;
    localparam logic [2:0]  FLOOR_RESET = 3'h0;
    localparam logic [7:0]  TMO_RESET   = 8'h0A;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [2:0] {
        ST_IDLE, ST_SELECT, ST_DISCHARGE, ST_HOLD, ST_APPLY, ST_ACCEPTED, ST_NOHS
    } ces_state_t;

    typedef enum logic [2:0] {
        MODE_PASS, MODE_SDP, MODE_DCP, MODE_CDP, MODE_DCE
    } ces_mode_t;

    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } ces_apb_req_t;

    // Controls toward the port power and data-pin analog
    typedef struct packed {
        logic       switchClose;   // Port power switch closed
        logic       vbusDischarge; // 100 ohm VBUS discharge path on
        logic       dataPullDown;  // 15 k pull-downs on both data pins
        logic       dataShort;     // data_short_resistor between pins
        logic       profileActive; // Profile signature driven
        logic [3:0] profileSel;    // Which profile signature
        logic       hsSwitchClose; // High-speed data switch closed
        logic       constCurrent;  // 1: constant current, 0: trip
    } ces_port_ctl_t;

endpackage

// ==== ces_sequencer.sv ====
// Functional notes
// (RULE1) DCP profile: VBUS on, data short kept
// (RULE2) Cycle mode presents enabled profiles in sequence
// (RULE3) Timer per profile; accept if current high
// (RULE4) High-speed switch open while cycling
// (RULE5) Emulation reset: switch open, VBUS discharged
// (RULE6) Switch stays open for hold time
// (RULE7) Data pins pulled down during reset
// (RULE8) Fixed order, custom last, custom off
// (RULE9) Custom-first bit moves custom to front
// (RULE10) Current high at expiry accepts, stops
// (RULE11) No current at expiry: reset, next
// (RULE12) Per-profile timeout, timeout enabled by default
// (RULE13) Retry repeats cycle while power enabled
// (RULE14) No retry: raise no-handshake, end cycle
// (RULE15) Trip or constant current per mode
// (RULE16) Floor versus limit picks mode after acceptance
// (RULE17) Floor code in bits 4..2 of 51h
// (RULE18) No-handshake flag set and kept
// (RULE19) No handshake: signatures off, switch configured
// (RULE20) DCP accepted: flag, short, switch open, CC
// (RULE21) DCP rejected: move to next profile
// (RULE22) Keeps cycling with nothing attached
// (RULE23) Mode from three select controls
// (RULE24) Synchronised comparator, loaded timeout counter
// (RULE25) Skip disabled profiles, abort on power off
//
// The implementer's own choices: the APB register port and the address map.
module ces_sequencer
    import ces_pkg::*;
#(
    parameter int TICK_LEN = ces_pkg::TICK_CYCLES  // Cycles per 1 ms tick
) (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire ces_pkg::ces_apb_req_t apbReq,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    input  wire logic                 port_power_enable,
    input  wire logic                 mode_select_one,
    input  wire logic                 mode_select_two,
    input  wire logic                 emulation_enable,
    input  wire logic                 overThreshold,
    output ces_pkg::ces_port_ctl_t    portCtl,
    output logic                      no_handshake_flag,
    output logic                      dcpDetected
);
    import ces_pkg::*;

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [4:0] pinRaw;           // Asynchronous pin group
    logic [4:0] sync1_q;          // First stage, read only by second
    logic [4:0] sync2_q;          // Second stage
    logic [4:0] sync3_q;          // Third stage
    logic [4:0] pin_q;            // Accepted levels
    assign pinRaw = {overThreshold, emulation_enable, mode_select_two,
                     mode_select_one, port_power_enable};

    // A change counts only once stages two and three agree
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
            sync3_q <= 5'h00;
            pin_q   <= 5'h00;
        end else begin
            sync1_q <= pinRaw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            pin_q   <= (sync2_q & sync3_q) | (pin_q & (sync2_q | sync3_q));
        end
    end

    wire pwrEn   = pin_q[0];
    wire overCur = pin_q[4];      // Comparator sampled at expiry (RULE24)

    // ==========================================================
    // Mode decode
    // ==========================================================
    ces_mode_t mode;
    always_comb begin
        case ({pin_q[1], pin_q[2], pin_q[3]})   // RULE23
            3'b001, 3'b101: mode = MODE_DCE;
            3'b011:         mode = MODE_DCP;
            3'b100:         mode = MODE_SDP;
            3'b111:         mode = MODE_CDP;
            default:        mode = MODE_PASS;  // 010, 110 and unused 000
        endcase
    end

    // ==========================================================
    // Registers
    // ==========================================================
    logic [12:0] ctrl_q;                      // Emulation control
    logic [3:0]  limit_q;                     // current_limit_setting
    logic [2:0]  floor_q;                     // accepted_floor_code
    logic [7:0]  tmo_q [NUM_PROFILES];        // profile_timeout in ms
    logic        pready_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;

    wire [9:0] idx     = apbReq.paddr[11:2];
    wire       setup   = apbReq.psel && !apbReq.penable;
    wire       wrDone  = apbReq.psel && apbReq.penable && pready_q && apbReq.pwrite;
    wire       hitTmo  = (idx >= IDX_TMO_BASE) && (idx < IDX_TMO_BASE + 10'(NUM_PROFILES));
    wire [3:0] tmoSel  = 4'(idx - IDX_TMO_BASE);
    wire       hitAny  = hitTmo || idx == IDX_STATUS || idx == IDX_CTRL
                         || idx == IDX_LIMIT || idx == IDX_CUST_LIM;
    wire [8:0] profEn  = ctrl_q[CTRL_EN_LSB +: NUM_PROFILES];
    wire       custFirst = ctrl_q[CTRL_FIRST_BIT];
    wire       retryEn = ctrl_q[CTRL_RETRY_BIT];
    wire       tmoEn   = ctrl_q[CTRL_TMO_BIT];
    wire       hsCfg   = ctrl_q[CTRL_HS_BIT];

    // Control, limit and floor registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_q  <= CTRL_RESET;      // Custom off, retry and timeout on  RULE8 RULE12 RULE13
            limit_q <= LIMIT_RESET;
            floor_q <= FLOOR_RESET;
        end else if (wrDone) begin
            if (idx == IDX_CTRL)
                ctrl_q <= apbReq.pwdata[12:0];
            if (idx == IDX_LIMIT)
                limit_q <= apbReq.pwdata[3:0];
            if (idx == IDX_CUST_LIM)
                floor_q <= apbReq.pwdata[FLOOR_LSB +: 3];   // RULE17
        end
    end

    // One timeout register per profile
    for (genvar g = 0; g < NUM_PROFILES; g++) begin : gTmo
        always_ff @(posedge clk) begin
            if (sys_rst)
                tmo_q[g] <= TMO_RESET;
            else if (wrDone && hitTmo && tmoSel == 4'(g))
                tmo_q[g] <= apbReq.pwdata[7:0];    // RULE12
        end
    end

    // ==========================================================
    // Sequencer state
    // ==========================================================
    ces_state_t  state_q, state_d;
    logic [3:0]  step_q, step_d;       // Position in the cycle, 0..8; 9 marks the end
    logic [15:0] cnt_q;                // Remaining ticks
    logic [31:0] pre_q;                // Tick prescaler
    logic        load;
    logic [15:0] loadVal;
    logic        noHs_q, dcp_q, noHsSet, dcpSet, cycleStart;

    // Map a cycle step to a profile; custom may be moved to the front
    function automatic logic [3:0] stepProfile(input logic [3:0] s, input logic first);
        if (!first)
            stepProfile = s;                        // RULE8
        else if (s == 4'h0)
            stepProfile = PROF_CUSTOM;              // RULE9
        else
            stepProfile = s - 4'h1;
    endfunction

    wire [3:0] curProf = stepProfile(step_q, custFirst);
    wire       expire  = (cnt_q == 16'h0000);
    wire       tick    = (pre_q == 32'(TICK_LEN - 1));
    wire       cycleOn = pwrEn && (mode == MODE_DCE);
    wire       stepEnd = (step_q > STEP_LAST);

    // Next state
    always_comb begin
        state_d    = state_q;
        step_d     = step_q;
        load       = 1'b0;
        loadVal    = 16'h0000;
        noHsSet    = 1'b0;
        dcpSet     = 1'b0;
        cycleStart = 1'b0;
        if (!cycleOn) begin
            state_d = ST_IDLE;                                  // RULE25
        end else begin
            case (state_q)
                ST_IDLE: begin
                    state_d    = ST_SELECT;                     // RULE2
                    step_d     = 4'h0;
                    cycleStart = 1'b1;
                end
                ST_SELECT: begin
                    if (stepEnd && retryEn) begin
                        step_d = 4'h0;                          // RULE13 RULE22
                    end else if (stepEnd) begin
                        state_d = ST_NOHS;                      // RULE14
                        noHsSet = 1'b1;
                    end else if (profEn[curProf]) begin
                        state_d = ST_DISCHARGE;                 // RULE5
                        load    = 1'b1;
                        loadVal = 16'(DISCHARGE_TICKS);
                    end else begin
                        step_d = step_q + 4'h1;                 // RULE25
                    end
                end
                ST_DISCHARGE: begin
                    if (expire) begin
                        state_d = ST_HOLD;                      // RULE6
                        load    = 1'b1;
                        loadVal = 16'(HOLD_TICKS);
                    end
                end
                ST_HOLD: begin
                    if (expire) begin
                        state_d = ST_APPLY;                     // RULE3
                        load    = 1'b1;
                        loadVal = {8'h00, tmo_q[curProf]};      // RULE24
                    end
                end
                ST_APPLY: begin
                    if (!tmoEn || (expire && overCur)) begin
                        state_d = ST_ACCEPTED;                  // RULE10
                        dcpSet  = (curProf == PROF_DCP);        // RULE20
                    end else if (expire) begin
                        state_d = ST_SELECT;                    // RULE11 RULE21
                        step_d  = step_q + 4'h1;
                    end
                end
                ST_ACCEPTED, ST_NOHS: state_d = state_q;
                default: state_d = ST_IDLE;
            endcase
        end
    end

    // State, step and sticky flags; a set beats a clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            step_q  <= 4'h0;
            noHs_q  <= 1'b0;
            dcp_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            step_q  <= step_d;
            noHs_q  <= noHsSet || (noHs_q && !cycleStart);      // RULE18
            dcp_q   <= dcpSet || (dcp_q && !cycleStart);
        end
    end

    // Tick prescaler and loaded down-counter
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pre_q <= 32'h0000_0000;
            cnt_q <= 16'h0000;
        end else if (load) begin
            pre_q <= 32'h0000_0000;
            cnt_q <= loadVal;
        end else begin
            pre_q <= tick ? 32'h0000_0000 : pre_q + 32'h0000_0001;
            if (tick && !expire)
                cnt_q <= cnt_q - 16'h0001;
        end
    end

    // ==========================================================
    // Port controls
    // ==========================================================
    ces_port_ctl_t ctl_d, ctl_q;
    wire limitLow = (limit_q <= LIMIT_1P5A);
    wire floorCc  = limitLow && !({1'b0, floor_q} <= limit_q);  // RULE16
    wire shortProf = (curProf == PROF_DCP) || (curProf == PROF_LEG2);

    always_comb begin
        ctl_d = '0;
        case (mode)
            MODE_PASS, MODE_SDP: begin
                ctl_d.switchClose   = pwrEn;
                ctl_d.hsSwitchClose = 1'b1;                     // RULE15
            end
            MODE_DCP: begin
                ctl_d.switchClose   = pwrEn;
                ctl_d.dataShort     = 1'b1;                     // RULE1
                ctl_d.profileActive = 1'b1;
                ctl_d.profileSel    = PROF_DCP;
                ctl_d.constCurrent  = limitLow;                 // RULE15
            end
            MODE_CDP: begin
                ctl_d.switchClose   = pwrEn;
                ctl_d.profileActive = 1'b1;
                ctl_d.profileSel    = PROF_CDP;
                ctl_d.hsSwitchClose = 1'b1;
                ctl_d.constCurrent  = limitLow;
            end
            MODE_DCE: begin
                // High-speed switch stays open unless no handshake says otherwise  RULE4
                case (state_q)
                    ST_DISCHARGE: begin
                        ctl_d.vbusDischarge = 1'b1;             // RULE5
                        ctl_d.dataPullDown  = 1'b1;             // RULE7
                    end
                    ST_HOLD: ctl_d.dataPullDown = 1'b1;         // RULE6 RULE7
                    ST_APPLY, ST_ACCEPTED: begin
                        ctl_d.switchClose   = 1'b1;
                        ctl_d.profileActive = 1'b1;
                        ctl_d.profileSel    = curProf;
                        ctl_d.dataShort     = shortProf;        // RULE1 RULE20
                        ctl_d.constCurrent  = (state_q == ST_APPLY || shortProf)
                                              ? limitLow : floorCc;  // RULE15 RULE16
                    end
                    ST_NOHS: begin
                        ctl_d.switchClose   = 1'b1;             // RULE19
                        ctl_d.hsSwitchClose = hsCfg;
                        ctl_d.constCurrent  = floorCc;          // RULE16
                    end
                    default: ctl_d = '0;
                endcase
                if (!pwrEn)
                    ctl_d.switchClose = 1'b0;
            end
            default: ctl_d = '0;
        endcase
    end

    // ==========================================================
    // APB slave: zero wait, answer registered in the setup cycle
    // ==========================================================
    wire [31:0] statusWord = {16'h0000, 1'b0, tmoEn, dcp_q, noHs_q,
                              step_q, curProf, 1'b0, state_q};
    wire [31:0] rdMux = (idx == IDX_STATUS)   ? statusWord :
                        (idx == IDX_CTRL)     ? {19'h00000, ctrl_q} :
                        (idx == IDX_LIMIT)    ? {28'h0000000, limit_q} :
                        (idx == IDX_CUST_LIM) ? {27'h0000000, floor_q, 2'b00} :
                        hitTmo                ? {24'h000000, tmo_q[tmoSel]} :
                                                32'h0000_0000;

    // Outputs all leave from flip-flops
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
            ctl_q     <= '0;
        end else begin
            pready_q  <= setup;
            prdata_q  <= setup ? rdMux : 32'h0000_0000;
            pslverr_q <= setup && !hitAny;       // Unmapped word
            ctl_q     <= ctl_d;
        end
    end

    assign pready            = pready_q;
    assign prdata            = prdata_q;
    assign pslverr           = pslverr_q;
    assign portCtl           = ctl_q;
    assign no_handshake_flag = noHs_q;
    assign dcpDetected       = dcp_q;

    // ==========================================================
    // Assertions
    // ==========================================================
    sequence sHoldToApply;
        state_q == ST_HOLD ##1 state_q == ST_APPLY;
    endsequence

    a_power_abort: assert property (@(posedge clk) disable iff (sys_rst)
        !pwrEn |=> state_q == ST_IDLE) else $error("cycle not aborted");  // RULE25
    a_reset_discharge: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == ST_DISCHARGE && cycleOn |=> !portCtl.switchClose && portCtl.vbusDischarge)
        else $error("reset not discharging");  // RULE5
    a_reset_pulldown: assert property (@(posedge clk) disable iff (sys_rst)
        (state_q == ST_DISCHARGE || state_q == ST_HOLD) && cycleOn |=> portCtl.dataPullDown)
        else $error("pull-downs missing");  // RULE7
    a_hold_then_close: assert property (@(posedge clk) disable iff (sys_rst)
        sHoldToApply ##0 cycleOn |=> portCtl.switchClose && portCtl.profileActive)
        else $error("switch not closed after hold");  // RULE6
    a_accept_current: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == ST_APPLY && expire && overCur && cycleOn |=> state_q == ST_ACCEPTED)
        else $error("profile not accepted");  // RULE10
    a_reject_next: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == ST_APPLY && tmoEn && expire && !overCur && cycleOn
        |=> state_q == ST_SELECT && step_q == $past(step_q) + 4'h1)
        else $error("reject did not advance");  // RULE11
    a_nohs_end: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == ST_SELECT && stepEnd && !retryEn && cycleOn
        |=> state_q == ST_NOHS ##1 no_handshake_flag)
        else $error("no handshake not raised");  // RULE14 RULE18
    a_custom_first: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == ST_SELECT && step_q == 4'h0 && custFirst && profEn[8] && cycleOn
        |=> state_q == ST_DISCHARGE && curProf == PROF_CUSTOM)
        else $error("custom not first");  // RULE9
    a_dcp_accept: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == ST_ACCEPTED && curProf == PROF_DCP && cycleOn
        |=> portCtl.dataShort && !portCtl.hsSwitchClose && portCtl.constCurrent == limitLow)
        else $error("dcp acceptance wrong");  // RULE20
    a_pass_trip: assert property (@(posedge clk) disable iff (sys_rst)
        (mode == MODE_PASS || mode == MODE_SDP) |=> !portCtl.constCurrent)
        else $error("pass-through not trip");  // RULE15

endmodule

// ==== ces_device_model.sv ====
// ==========================================
// Attached portable device
// ==========================================
module ces_device_model
    import ces_pkg::*;
(
    input  wire logic                   acceptEn,
    input  wire logic [3:0]             acceptSel,
    input  wire ces_pkg::ces_port_ctl_t portCtl,
    output logic                        overThreshold
);
    timeunit 1ns;
    timeprecision 1ns;
    // Draws charge only while powered and shown the one signature it knows
    assign overThreshold = acceptEn && portCtl.switchClose
        && portCtl.profileActive && portCtl.profileSel == acceptSel;
endmodule

// ==== testbench.sv ====
module testbench
    import ces_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // Signals
    // ==========================================
    typedef struct {logic [11:0] a; logic [31:0] d; logic e;} ces_row_t;
    logic          clk, sysRst, powerEn, modeOne, acceptEn, overTh, noHs, dcpDet;
    logic          pready, pslverr, er, sawDis, badRst, modeTwo, emEn;
    logic [3:0]    acceptSel;
    logic [31:0]   prdata, rd;
    logic [3:0]    seen[$];
    ces_apb_req_t  req;
    ces_port_ctl_t portCtl;
    int            n_mismatch, checks_done;
    // Register defaults, plus one unmapped word
    ces_row_t rows [6] = '{'{12'h048, 32'h4000, 0}, '{12'h058, 32'h0CFF, 0},
        '{12'h064, 32'h8, 0}, '{12'h0C0, 32'h0A, 0}, '{12'h144, 32'h0, 0},
        '{12'h004, 32'h0, 1}};
    ces_sequencer #(.TICK_LEN(4)) DUT (.clk(clk), .sys_rst(sysRst), .apbReq(req),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .port_power_enable(powerEn),
        .mode_select_one(modeOne), .mode_select_two(modeTwo), .emulation_enable(emEn),
        .overThreshold(overTh), .portCtl(portCtl), .no_handshake_flag(noHs),
        .dcpDetected(dcpDet));
    ces_device_model PD (.acceptEn(acceptEn), .acceptSel(acceptSel), .portCtl(portCtl),
        .overThreshold(overTh));
    // ==========================================
    // Monitor: profile order and reset shape
    // ==========================================
    always @(posedge clk) begin
        if (portCtl.vbusDischarge === 1'b1) sawDis <= 1'b1;
        if (portCtl.vbusDischarge === 1'b1 && (portCtl.switchClose !== 1'b0
            || portCtl.dataPullDown !== 1'b1)) badRst <= 1'b1;
        if (portCtl.profileActive === 1'b1 && (seen.size() == 0
            || seen[$] != portCtl.profileSel)) seen.push_back(portCtl.profileSel);
    end
    // ==========================================
    // Tasks
    // ==========================================
    task automatic give_verdict();
        if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask
    // Request held until pready is sampled; bounded wait
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
        @(posedge clk);
        req.penable <= 1'b1;
        for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge clk);
        rd = prdata;
        er = pslverr;
        req <= '0;
        if (i == 20) begin
            n_mismatch++;
            give_verdict();
        end
    endtask
    task automatic waitFor(input int k);
        int i;
        for (i = 0; i < 8000; i++) begin
            @(posedge clk);
            if (k == 0 && dcpDet === 1'b1) break;
            if (k == 1 && noHs === 1'b1) break;
            if (k == 2 && portCtl.profileActive === 1'b1) break;
        end
        if (i == 8000) begin
            n_mismatch++;
            give_verdict();
        end
    endtask
    // Power stays off until configuration is in
    task automatic restart(input logic m1);
        powerEn <= 1'b0;
        modeOne <= m1;
        sysRst <= 1'b1;
        repeat (4) @(posedge clk);
        sysRst <= 1'b0;
        seen.delete();
    endtask
    // ==========================================
    // Stimulus
    // ==========================================
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    initial begin
        {sysRst, powerEn, modeOne, modeTwo, emEn, acceptEn, sawDis, badRst} = 8'h88;
        {acceptSel, req, n_mismatch, checks_done} = '0;
        restart(1'b0);
        for (int r = 0; r < 6; r++) begin
            apb(1'b0, rows[r].a, 32'h0);
            chk("rdata", rows[r].d, rd);
            chk("slverr", rows[r].e, er);
        end
        // Timeouts are programmable one profile at a time
        apb(1'b1, 12'h0C4, 32'h3);
        apb(1'b0, 12'h0C4, 32'h0);
        chk("tmo", 32'h3, rd);
        // Device takes DCP only; limit at 1.5 A
        restart(1'b0);
        apb(1'b1, 12'h064, 32'h6);
        {acceptSel, acceptEn, powerEn} <= {PROF_DCP, 2'b11};
        waitFor(0);
        repeat (2) @(posedge clk);
        chk("first", PROF_LEG1, seen[0]);
        chk("second", PROF_DCP, seen[1]);
        chk("short", 1, portCtl.dataShort);
        chk("hs", 0, portCtl.hsSwitchClose);
        chk("cc", 1, portCtl.constCurrent);
        chk("erst", 1, sawDis & ~badRst);
        // No retry, floor above limit, mode 101
        restart(1'b1);
        acceptEn <= 1'b0;
        apb(1'b1, 12'h058, 32'h1801);
        apb(1'b1, 12'h064, 32'h4);
        apb(1'b1, 12'h144, 32'h1C);
        powerEn <= 1'b1;
        waitFor(1);
        repeat (50) @(posedge clk);
        chk("nohs", 1, noHs);
        chk("sig", 0, portCtl.profileActive);
        chk("hs", 1, portCtl.hsSwitchClose);
        chk("cc", 1, portCtl.constCurrent);
        chk("tries", 1, seen.size());
        // Custom first, then power drop aborts
        restart(1'b0);
        {acceptSel, acceptEn} <= {PROF_CUSTOM, 1'b1};
        apb(1'b1, 12'h058, 32'h0F01);
        powerEn <= 1'b1;
        waitFor(2);
        chk("first", PROF_CUSTOM, portCtl.profileSel);
        powerEn <= 1'b0;
        repeat (12) @(posedge clk);
        chk("abort", 0, portCtl.profileActive);
        // Fixed modes: DCP at 1.5 A, then pass-through
        restart(1'b0);
        apb(1'b1, 12'h064, 32'h6);
        {modeTwo, powerEn} <= 2'b11;
        repeat (12) @(posedge clk);
        chk("dcpshort", 1, portCtl.dataShort);
        chk("dcpsel", PROF_DCP, portCtl.profileSel);
        chk("dcpcc", 1, portCtl.constCurrent);
        emEn <= 1'b0;
        repeat (12) @(posedge clk);
        chk("passhs", 1, portCtl.hsSwitchClose);
        chk("passcc", 0, portCtl.constCurrent);
        give_verdict();
    end
endmodule
